/* wdog_pkg.sv */
// Purpose: Shared constants and types for the two-stage watchdog.
// Assumes: 200 MHz mclk, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package wdog_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ACTION  = 8'h04;
   localparam logic [7:0] OFS_TIME1   = 8'h08;
   localparam logic [7:0] OFS_TIME2   = 8'h0c;
   localparam logic [7:0] OFS_SERVICE = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_IRQ     = 8'h18;
   localparam logic [7:0] OFS_MASK    = 8'h1c;

   // Field positions.
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_SEL_BIT = 1;
   localparam int ACT2_LSB     = 4;

   // Service key, arbitrary value chosen for this block.
   localparam logic [31:0] SERVICE_KEY = 32'h0000_5a5a;

   // Reset values.
   localparam logic [31:0] TIME_RST   = 32'h0000_0400;
   localparam logic [3:0]  ACTION_RST = 4'h0;

   // Request pulses on the action outputs last PULSE_CYC + 1 cycles.
   localparam int PULSE_NS     = 20;
   localparam int CLK_NS       = 5;
   localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;

   // Interrupt status bits.
   localparam int IRQ_EXP1 = 0;
   localparam int IRQ_EXP2 = 1;

   // Action codes.
   localparam logic [3:0] ACT_NONE      = 4'h0;
   localparam logic [3:0] ACT_RESET     = 4'h1;
   localparam logic [3:0] ACT_DELAY     = 4'h5;
   localparam logic [3:0] ACT_PIN       = 4'h8;
   localparam logic [3:0] ACT_RESET_PIN = 4'h9;
   localparam logic [3:0] ACT_NMI_PIN   = 4'ha;
   localparam logic [3:0] ACT_SMI_PIN   = 4'hb;
   localparam logic [3:0] ACT_SCI_PIN   = 4'hc;
   localparam logic [3:0] ACT_DLY_PIN   = 4'hd;

   typedef enum logic [1:0] {ST_IDLE, ST_STAGE1, ST_STAGE2, ST_DONE} wd_state_e;

   // Action request outputs.
   typedef struct packed {
      logic reset_req;
      logic nmi_req;
      logic smi_req;
      logic sci_req;
   } action_s;

   // Whole state of the watchdog.
   typedef struct packed {
      wd_state_e    st;
      logic         enable;
      logic         pin_sel;
      logic [3:0]   act1;
      logic [3:0]   act2;
      logic [31:0]  time1;
      logic [31:0]  time2;
      logic [31:0]  count;
      logic         timeout_pin;
      logic [1:0]   irq_stat;
      logic [1:0]   irq_mask;
      action_s      act;
      logic [7:0]   pulse;
      logic [31:0]  prdata;
   } wd_reg_s;

endpackage : wdog_pkg

/* dual_stage_watchdog.sv */
// Purpose: Two-stage watchdog timer with per-stage timeout and action code.
// Assumes: One clock mclk, asynchronous active-low reset, APB slave, zero wait states.
// Notes:   Timeout output is cleared only by reset.
`timescale 1ns/10ps
module dual_stage_watchdog (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             watchdog_timeout_out,
   output logic             reset_req,
   output logic             nmi_req,
   output logic             sys_mgmt_irq_req,
   output logic             sys_ctrl_irq_req,
   output logic             irq
);

   wdog_pkg::wd_reg_s r;
   wdog_pkg::wd_reg_s next_r;

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic service;
   logic expire;
   logic [3:0] cur_act;
   logic cur_stage2;

   // APB access is taken in the access phase; the slave never stalls.
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= wdog_pkg::OFS_MASK);
   assign service = wr_en && (paddr == wdog_pkg::OFS_SERVICE) && (pwdata == wdog_pkg::SERVICE_KEY);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   assign cur_stage2 = (r.st == wdog_pkg::ST_STAGE2);
   assign cur_act    = cur_stage2 ? r.act2 : r.act1;
   assign expire     = ((r.st == wdog_pkg::ST_STAGE1) || cur_stage2) && (r.count == 32'h0000_0001);

   // Helper: does an action code drive the timeout pin.
   function automatic logic code_has_pin(input logic [3:0] c);
      code_has_pin = c[3];
   endfunction : code_has_pin

   // Helper: an action code is legal for the given stage.
   function automatic logic [3:0] filter_code(input logic [3:0] c, input logic stage2);
      logic ok;
      ok = 1'b0;
      case (c)
         wdog_pkg::ACT_NONE, wdog_pkg::ACT_RESET, wdog_pkg::ACT_PIN,
         wdog_pkg::ACT_RESET_PIN, wdog_pkg::ACT_NMI_PIN, wdog_pkg::ACT_SMI_PIN,
         wdog_pkg::ACT_SCI_PIN, wdog_pkg::ACT_DLY_PIN: ok = 1'b1;
         wdog_pkg::ACT_DELAY: ok = !stage2;
         default: ok = 1'b0;
      endcase
      // An illegal code is stored as disabled so the stage never acts on garbage.
      filter_code = ok ? c : wdog_pkg::ACT_NONE;
   endfunction : filter_code

   // Next state: registers, sequencer, actions and interrupt status.
   always_comb begin
      next_r = r;
      // Action requests are short pulses, counted down here.
      if (r.pulse != 8'h00) begin
         next_r.pulse = r.pulse - 8'h01;
      end else begin
         next_r.act = '0;
      end

      if (wr_en) begin
         case (paddr)
            wdog_pkg::OFS_CTRL: begin
               next_r.enable  = pwdata[wdog_pkg::CTRL_EN_BIT];
               next_r.pin_sel = pwdata[wdog_pkg::CTRL_SEL_BIT];
            end
            wdog_pkg::OFS_ACTION: begin
               next_r.act1 = filter_code(pwdata[3:0], 1'b0);
               next_r.act2 = filter_code(pwdata[wdog_pkg::ACT2_LSB +: 4], 1'b1);
            end
            wdog_pkg::OFS_TIME1: next_r.time1 = (pwdata == 32'h0) ? 32'h1 : pwdata;
            wdog_pkg::OFS_TIME2: next_r.time2 = (pwdata == 32'h0) ? 32'h1 : pwdata;
            wdog_pkg::OFS_MASK:  next_r.irq_mask = pwdata[1:0];
            default: ;
         endcase
      end

      // Sequencer.
      case (r.st)
         wdog_pkg::ST_IDLE: begin
            if (r.enable) begin
               next_r.st    = wdog_pkg::ST_STAGE1;
               next_r.count = r.time1;
            end
         end
         wdog_pkg::ST_STAGE1, wdog_pkg::ST_STAGE2: begin
            next_r.count = r.count - 32'h1;
            // A disabled first stage is passed over after one cycle, so it delays stage two by one cycle only.
            if (!cur_stage2 && (r.act1 == wdog_pkg::ACT_NONE)) begin
               next_r.st    = wdog_pkg::ST_STAGE2;
               next_r.count = r.time2;
            end else if (expire) begin
               if (cur_act != wdog_pkg::ACT_NONE) begin
                  next_r.irq_stat[cur_stage2 ? wdog_pkg::IRQ_EXP2 : wdog_pkg::IRQ_EXP1] = 1'b1;
                  next_r.pulse = 8'(wdog_pkg::PULSE_CYC);
                  next_r.act.reset_req = (cur_act == wdog_pkg::ACT_RESET) ||
                                         (cur_act == wdog_pkg::ACT_RESET_PIN);
                  next_r.act.nmi_req = (cur_act == wdog_pkg::ACT_NMI_PIN);
                  next_r.act.smi_req = (cur_act == wdog_pkg::ACT_SMI_PIN);
                  next_r.act.sci_req = (cur_act == wdog_pkg::ACT_SCI_PIN);
                  // Pin attaches to the selected stage only; sticky until reset.
                  if (code_has_pin(cur_act) && (r.pin_sel == cur_stage2)) begin
                     next_r.timeout_pin = 1'b1;
                  end
               end
               if (cur_stage2) begin
                  next_r.st = wdog_pkg::ST_DONE;
               end else begin
                  next_r.st    = wdog_pkg::ST_STAGE2;
                  next_r.count = r.time2;
               end
            end
         end
         wdog_pkg::ST_DONE: ;
         default: next_r.st = wdog_pkg::ST_IDLE;
      endcase

      // Service restarts stage one from any running state.
      if (service && r.enable) begin
         next_r.st    = wdog_pkg::ST_STAGE1;
         next_r.count = r.time1;
      end
      if (wr_en && (paddr == wdog_pkg::OFS_CTRL) && !pwdata[wdog_pkg::CTRL_EN_BIT]) begin
         next_r.st = wdog_pkg::ST_IDLE;
      end

      // Write-one-to-clear, but a bit newly set by an event in the same cycle wins.
      if (wr_en && (paddr == wdog_pkg::OFS_IRQ)) begin
         next_r.irq_stat = next_r.irq_stat & ~(pwdata[1:0] & ~(next_r.irq_stat & ~r.irq_stat));
      end

      // Read data mux; unmapped addresses read zero.
      next_r.prdata = 32'h0;
      if (rd_en) begin
         case (paddr)
            wdog_pkg::OFS_CTRL:   next_r.prdata = {30'h0, r.pin_sel, r.enable};
            wdog_pkg::OFS_ACTION: next_r.prdata = {24'h0, r.act2, r.act1};
            wdog_pkg::OFS_TIME1:  next_r.prdata = r.time1;
            wdog_pkg::OFS_TIME2:  next_r.prdata = r.time2;
            wdog_pkg::OFS_STATUS: next_r.prdata = {r.count[27:0], r.timeout_pin, 1'b0, r.st};
            wdog_pkg::OFS_IRQ:    next_r.prdata = {30'h0, r.irq_stat};
            wdog_pkg::OFS_MASK:   next_r.prdata = {30'h0, r.irq_mask};
            default:              next_r.prdata = 32'h0;
         endcase
      end
   end

   // State register; everything resets to constants, which also clears the pin.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r          <= '0;
         r.st       <= wdog_pkg::ST_IDLE;
         r.act1     <= wdog_pkg::ACTION_RST;
         r.act2     <= wdog_pkg::ACTION_RST;
         r.time1    <= wdog_pkg::TIME_RST;
         r.time2    <= wdog_pkg::TIME_RST;
         r.count    <= 32'h0;
         r.timeout_pin <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // Read data is presented combinationally so zero-wait reads see it in the access phase.
   always_comb begin
      prdata = 32'h0;
      if (rd_en) begin
         case (paddr)
            wdog_pkg::OFS_CTRL:   prdata = {30'h0, r.pin_sel, r.enable};
            wdog_pkg::OFS_ACTION: prdata = {24'h0, r.act2, r.act1};
            wdog_pkg::OFS_TIME1:  prdata = r.time1;
            wdog_pkg::OFS_TIME2:  prdata = r.time2;
            wdog_pkg::OFS_STATUS: prdata = {r.count[27:0], r.timeout_pin, 1'b0, r.st};
            wdog_pkg::OFS_IRQ:    prdata = {30'h0, r.irq_stat};
            wdog_pkg::OFS_MASK:   prdata = {30'h0, r.irq_mask};
            default:              prdata = 32'h0;
         endcase
      end
   end

   assign watchdog_timeout_out = r.timeout_pin;
   assign reset_req        = r.act.reset_req;
   assign nmi_req          = r.act.nmi_req;
   assign sys_mgmt_irq_req = r.act.smi_req;
   assign sys_ctrl_irq_req = r.act.sci_req;
   assign irq              = |(r.irq_stat & r.irq_mask);

   // Assertions.
   property p_skip_disabled;
      @(posedge mclk) disable iff (!rst_n)
      expire && (cur_act == wdog_pkg::ACT_NONE) |=> !reset_req && !nmi_req && !sys_mgmt_irq_req && !sys_ctrl_irq_req;
   endproperty
   a_skip_disabled: assert property (p_skip_disabled) else $error("Disabled stage acted.");

   property p_reset_act;
      @(posedge mclk) disable iff (!rst_n)
      expire && (cur_act == wdog_pkg::ACT_RESET) |=> reset_req && !nmi_req;
   endproperty
   a_reset_act: assert property (p_reset_act) else $error("Reset action missing.");

   property p_delay_stage2;
      @(posedge mclk) disable iff (!rst_n)
      r.act2 != wdog_pkg::ACT_DELAY;
   endproperty
   a_delay_stage2: assert property (p_delay_stage2) else $error("Delay code in stage two.");

   property p_pin_only;
      @(posedge mclk) disable iff (!rst_n)
      expire && (cur_act == wdog_pkg::ACT_PIN) |=> !reset_req && !nmi_req && !sys_mgmt_irq_req && !sys_ctrl_irq_req;
   endproperty
   a_pin_only: assert property (p_pin_only) else $error("Pin-only code raised a request.");

   property p_nmi_act;
      @(posedge mclk) disable iff (!rst_n)
      expire && (cur_act == wdog_pkg::ACT_NMI_PIN) |=> nmi_req [*2];
   endproperty
   a_nmi_act: assert property (p_nmi_act) else $error("NMI request too short.");

   property p_sci_act;
      @(posedge mclk) disable iff (!rst_n)
      expire && (cur_act == wdog_pkg::ACT_SCI_PIN) |=> sys_ctrl_irq_req;
   endproperty
   a_sci_act: assert property (p_sci_act) else $error("SYS_CTRL_IRQ_REQ request missing.");

   property p_pin_sel;
      @(posedge mclk) disable iff (!rst_n)
      expire && cur_act[3] && (r.pin_sel == cur_stage2) |=> watchdog_timeout_out;
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("Timeout pin not asserted.");

   property p_pin_sticky;
      @(posedge mclk) disable iff (!rst_n)
      watchdog_timeout_out |=> watchdog_timeout_out;
   endproperty
   a_pin_sticky: assert property (p_pin_sticky) else $error("Timeout pin cleared at runtime.");

   property p_service;
      @(posedge mclk) disable iff (!rst_n)
      service && r.enable && !(wr_en && paddr == wdog_pkg::OFS_CTRL) |=> (r.st == wdog_pkg::ST_STAGE1) && (r.count == $past(r.time1));
   endproperty
   a_service: assert property (p_service) else $error("Service did not restart stage one.");

   property p_stage_seq;
      @(posedge mclk) disable iff (!rst_n)
      expire && !cur_stage2 && !service && !wr_en |=> (r.st == wdog_pkg::ST_STAGE2);
   endproperty
   a_stage_seq: assert property (p_stage_seq) else $error("Stage two did not follow.");

endmodule : dual_stage_watchdog

/* host_system_model.sv */
// Purpose: Behavioural system side that receives the watchdog action requests.
// Assumes: Requests are active-high pulses synchronous to mclk.
// Notes:   It only measures; a real reset controller would also restart the module.
`timescale 1ns/10ps
module host_system_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] req,
   output logic      [7:0] width
);
   logic [7:0] run;

   // Count the high cycles of any request and keep the length of the last pulse.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run   <= 8'h00;
         width <= 8'h00;
      end else if (|req) begin
         run <= run + 8'h01;
      end else if (run != 8'h00) begin
         width <= run;
         run   <= 8'h00;
      end
   end
endmodule : host_system_model

/* dual_stage_watchdog_test.sv */
// Purpose: Self-checking bench for the two-stage watchdog.
// Assumes: Zero-wait APB slave; stage times are short values written by the bench.
// Notes:   Read and request notes are queued and checked by a separate monitor.
`timescale 1ns/10ps
module dual_stage_watchdog_test;
   logic        mclk    = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        watchdog_timeout_out;
   logic        reset_req;
   logic        nmi_req;
   logic        sys_mgmt_irq_req;
   logic        sys_ctrl_irq_req;
   logic        irq;
   logic [7:0]  width;
   logic [3:0]  prev_act = 4'h0;
   logic [32:0] exp_rd[$];
   logic [3:0]  exp_act[$];
   logic [3:0]  codes[9] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
   logic [3:0]  code;
   logic        m;
   int          t;
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles      = 0;
   wire  [3:0]  act = {reset_req, nmi_req, sys_mgmt_irq_req, sys_ctrl_irq_req};

   dual_stage_watchdog u_dual_stage_watchdog (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_timeout_out(watchdog_timeout_out), .reset_req(reset_req), .nmi_req(nmi_req),
      .sys_mgmt_irq_req(sys_mgmt_irq_req), .sys_ctrl_irq_req(sys_ctrl_irq_req), .irq(irq));

   host_system_model u_host_system_model (.mclk(mclk), .rst_n(rst_n), .req(act), .width(width));

   // Free-running 200 MHz clock.
   always #2.5 mclk = ~mclk;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // A hang is cut short well above the fewer than a thousand cycles the tests need.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   // Oldest note is compared whenever a read completes or a new request pulse starts.
   always @(posedge mclk) begin
      prev_act <= act;
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, exp_rd.pop_front());
      if (act != 4'h0 && prev_act == 4'h0)
         check(33'(act), 33'(exp_act.pop_front()));
   end

   function automatic logic [3:0] act_of(input logic [3:0] c);
      case (c)
         4'h1, 4'h9: act_of = 4'h8;
         4'ha:       act_of = 4'h4;
         4'hb:       act_of = 4'h2;
         4'hc:       act_of = 4'h1;
         default:    act_of = 4'h0;
      endcase
   endfunction : act_of

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Unaligned or unmapped places answer with an error and zero data.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back({(a > 8'h1c || a[1:0] != 2'b00), e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic do_reset();
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset

   // Main sequence: register defaults, every action code, servicing, pin attachment.
   initial begin
      void'($urandom(32'hd6d8));
      do_reset();
      rd(wdog_pkg::OFS_CTRL, 32'h0);
      rd(wdog_pkg::OFS_TIME1, wdog_pkg::TIME_RST);
      rd(wdog_pkg::OFS_TIME2, wdog_pkg::TIME_RST);
      rd(wdog_pkg::OFS_MASK, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h02, 32'h0);
      wr(wdog_pkg::OFS_ACTION, 32'h85);
      rd(wdog_pkg::OFS_ACTION, 32'h85);
      wr(wdog_pkg::OFS_ACTION, 32'h52);
      rd(wdog_pkg::OFS_ACTION, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         code = codes[i];
         m    = 1'($urandom_range(1, 0));
         t    = $urandom_range(12, 4);
         do_reset();
         check(33'(watchdog_timeout_out), 33'h0);
         wr(wdog_pkg::OFS_TIME1, 32'(t));
         wr(wdog_pkg::OFS_TIME2, 32'h40);
         wr(wdog_pkg::OFS_ACTION, {28'h0, code});
         wr(wdog_pkg::OFS_MASK, {31'h0, m});
         if (act_of(code) != 4'h0)
            exp_act.push_back(act_of(code));
         wr(wdog_pkg::OFS_CTRL, 32'h1);
         repeat (t + wdog_pkg::PULSE_CYC + 12) @(posedge mclk);
         check(33'(watchdog_timeout_out), 33'(code[3]));
         check(33'(irq), 33'((code != 4'h0) && m));
         check(33'(exp_act.size()), 33'h0);
         if (act_of(code) != 4'h0)
            check(33'(width), 33'(wdog_pkg::PULSE_CYC + 1));
         rd(wdog_pkg::OFS_IRQ, {31'h0, code != 4'h0});
         wr(wdog_pkg::OFS_IRQ, 32'h1);
         rd(wdog_pkg::OFS_IRQ, 32'h0);
         check(33'(irq), 33'h0);
         $display("test action code %h done", code);
      end
      // Regular service keeps the first stage from expiring.
      do_reset();
      wr(wdog_pkg::OFS_TIME1, 32'd20);
      wr(wdog_pkg::OFS_ACTION, 32'h8);
      wr(wdog_pkg::OFS_CTRL, 32'h1);
      repeat (6) begin
         repeat (8) @(posedge mclk);
         wr(wdog_pkg::OFS_SERVICE, wdog_pkg::SERVICE_KEY);
      end
      check(33'(watchdog_timeout_out), 33'h0);
      repeat (30) @(posedge mclk);
      check(33'(watchdog_timeout_out), 33'h1);
      $display("test service done");
      // Pin attached to the second stage ignores the first stage's pin code.
      do_reset();
      wr(wdog_pkg::OFS_TIME1, 32'd8);
      wr(wdog_pkg::OFS_TIME2, 32'd40);
      wr(wdog_pkg::OFS_ACTION, 32'h98);
      exp_act.push_back(4'h8);
      wr(wdog_pkg::OFS_CTRL, 32'h3);
      repeat (25) @(posedge mclk);
      check(33'(watchdog_timeout_out), 33'h0);
      repeat (50) @(posedge mclk);
      check(33'(watchdog_timeout_out), 33'h1);
      check(33'(exp_act.size()), 33'h0);
      rd(wdog_pkg::OFS_IRQ, 32'h3);
      $display("test pin select done");
      stop_test();
   end
endmodule : dual_stage_watchdog_test
